// [design/ir_comp_trigger_control.sv]
// ir compensation, current interrupt timing, scan trigger and output nulling settings
// assumes an apb master on pclk, synchronous inputs, and an analog side taking the outputs
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ns
`include "ir_ctrl_regs.svh"

module ir_comp_trigger_control #(
	parameter int unsigned US_CYC = `US_CYCLES,
	parameter int unsigned MEAS_US = 1000
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_trig,
	input wire logic front_trig,
	input wire logic line_zero,
	input wire logic scan_done,
	input wire logic signed [15:0] bias_meas_e,
	input wire logic signed [15:0] bias_meas_i,
	output logic ir_comp_on,
	output logic pos_feedback_on,
	output logic [11:0] pfb_amount,
	output logic [7:0] ci_corr_pct,
	output logic cell_switch_open,
	output logic sample_open_pulse,
	output logic sample_close_pulse,
	output logic scan_start,
	output logic scanning,
	output logic [13:0] rotator_mv,
	output logic signed [15:0] null_e_mv,
	output logic signed [15:0] null_i_milli,
	output logic lpf_e_on,
	output logic lpf_i_on
);

	typedef struct packed {
		logic [6:0] ctrl;
		logic [11:0] pfb;
		logic [19:0] topen;
		logic [13:0] tperiod;
		logic [7:0] corr;
		logic [19:0] dly_open;
		logic [19:0] dly_close;
		logic [13:0] rotate;
		logic signed [15:0] null_e;
		logic signed [15:0] null_i;
		logic cmd_err;
		ir_ctrl_pkg::scan_e scan;
		ir_ctrl_pkg::ci_e ci;
		ir_ctrl_pkg::bias_e br;
		logic ext_q;
		logic [7:0] us_div;
		logic [33:0] per_cnt;
		logic [19:0] open_cnt;
		logic [19:0] samp_cnt;
		logic samp_o_armed;
		logic samp_c_armed;
		logic samp_o;
		logic samp_c;
		logic start;
		logic [19:0] meas_cnt;
		logic [31:0] rdata;
	} state_s;

	state_s q, d;

	logic us_tick;
	logic wr_acc;
	logic rd_acc;
	logic [31:0] wmask;
	logic [31:0] wval;
	logic sw_trig;
	logic ext_edge;

	// clamp to boosted or normal minimum and an upper limit
	function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
		if (v < lo) begin
			return lo;
		end else if (v > hi) begin
			return hi;
		end
		return v;
	endfunction

	function automatic logic signed [15:0] clamp_s(input logic signed [31:0] v, input logic [31:0] lim);
		logic signed [31:0] l;
		l = $signed(lim);
		if (v < -l) begin
			return 16'(-l);
		end else if (v > l) begin
			return 16'(l);
		end
		return 16'(v);
	endfunction

	always_comb begin
		logic boost;
		logic [31:0] r;
		logic [31:0] lo;
		boost = 1'b0;
		r = 32'h00000000;
		lo = 32'h00000000;
		d = q;
		d.samp_o = 1'b0;
		d.samp_c = 1'b0;
		d.start = 1'b0;
		wr_acc = psel && penable && pwrite;
		// read data loads in the setup cycle so it already stands at the access edge
		rd_acc = psel && !penable && !pwrite;
		wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
		wval = 32'h00000000;
		sw_trig = 1'b0;
		us_tick = (32'(q.us_div) == US_CYC - 1);
		d.us_div = us_tick ? 8'h00 : q.us_div + 8'h01;
		boost = q.ctrl[`CTRL_BOOST];

		if (wr_acc) begin
			unique case (paddr)
				`OFS_CTRL: begin
					wval = (32'(q.ctrl) & ~wmask) | (pwdata & wmask);
					d.ctrl = wval[6:0];
				end
				`OFS_PFB: d.pfb = 12'(clamp(pwdata, 32'h0, `PFB_MAX));
				`OFS_TOPEN: begin
					lo = boost ? `TOPEN_BOOST_MIN_US : `TOPEN_STEP_US;
					r = clamp(pwdata, lo, `TOPEN_MAX_US);
					d.topen = 20'(r - (r % `TOPEN_STEP_US));
				end
				`OFS_TPERIOD: begin
					lo = boost ? `PERIOD_BOOST_MIN_MS : `PERIOD_MIN_MS;
					d.tperiod = 14'(clamp(pwdata, lo, `PERIOD_MAX_MS));
				end
				`OFS_CORR: d.corr = 8'(clamp(pwdata, 32'h0, `CORR_MAX));
				`OFS_DLY_OPEN: begin
					lo = boost ? `DLY_OPEN_BOOST_MIN_US : 32'h0;
					d.dly_open = 20'(clamp(pwdata, lo, `DLY_MAX_US));
				end
				`OFS_DLY_CLOSE: begin
					lo = boost ? `DLY_CLOSE_BOOST_MIN_US : 32'h0;
					d.dly_close = 20'(clamp(pwdata, lo, `DLY_MAX_US));
				end
				`OFS_TRIG: begin
					if (pwdata[`TRIG_ARM] && q.scan == ir_ctrl_pkg::SC_IDLE) begin
						d.scan = ir_ctrl_pkg::SC_ARMED;
					end
					sw_trig = pwdata[`TRIG_SW];
					if (pwdata[`TRIG_STOP]) begin
						d.scan = ir_ctrl_pkg::SC_IDLE;
					end
				end
				`OFS_ROTATE: d.rotate = 14'(clamp(pwdata, 32'h0, `ROTATE_MAX_MV));
				`OFS_NULL_E: begin
					if (q.br == ir_ctrl_pkg::BR_OFF) begin
						d.cmd_err = 1'b1;
					end else begin
						d.null_e = clamp_s(pwdata, `NULL_E_LIM_MV);
						d.br = ir_ctrl_pkg::BR_HOLD;
					end
				end
				`OFS_NULL_I: begin
					if (q.br == ir_ctrl_pkg::BR_OFF) begin
						d.cmd_err = 1'b1;
					end else begin
						d.null_i = clamp_s(pwdata, `NULL_I_LIM);
						d.br = ir_ctrl_pkg::BR_HOLD;
					end
				end
				// write one clears the error flag
				`OFS_STATUS: begin
					if (pwdata[`ST_CMD_ERR]) begin
						d.cmd_err = 1'b0;
					end
				end
				default: ;
			endcase
		end

		if (!d.ctrl[`CTRL_BIAS_EN]) begin
			d.br = ir_ctrl_pkg::BR_OFF;
			d.null_e = 16'sh0000;
			d.null_i = 16'sh0000;
		end else if (q.br == ir_ctrl_pkg::BR_OFF) begin
			d.br = ir_ctrl_pkg::BR_MEAS;
			d.meas_cnt = 20'h00000;
		end else if (q.br == ir_ctrl_pkg::BR_MEAS && us_tick) begin
			if (32'(q.meas_cnt) >= MEAS_US - 1) begin
				d.null_e = -bias_meas_e;
				d.null_i = -bias_meas_i;
				d.br = ir_ctrl_pkg::BR_HOLD;
			end else begin
				d.meas_cnt = q.meas_cnt + 20'h00001;
			end
		end

		// scan trigger sequencing
		ext_edge = ext_trig && !q.ext_q;
		d.ext_q = ext_trig;
		unique case (q.scan)
			ir_ctrl_pkg::SC_IDLE: begin
				if (front_trig) begin
					d.start = 1'b1;
				// line sync off starts at once
				end else if (sw_trig && !q.ctrl[`CTRL_LINE_SYNC]) begin
					d.start = 1'b1;
				end else if (sw_trig) begin
					d.scan = ir_ctrl_pkg::SC_WAIT_LINE;
				end
			end
			ir_ctrl_pkg::SC_ARMED: begin
				// start only on edge
				// a disarm written in the same cycle beats the edge
				if (ext_edge && d.scan != ir_ctrl_pkg::SC_IDLE) begin
					d.start = 1'b1;
				end
			end
			ir_ctrl_pkg::SC_WAIT_LINE: begin
				if (line_zero && d.scan != ir_ctrl_pkg::SC_IDLE) begin
					d.start = 1'b1;
				end
			end
			ir_ctrl_pkg::SC_RUN: begin
				if (scan_done) begin
					d.scan = ir_ctrl_pkg::SC_IDLE;
				end
			end
		endcase
		if (d.start) begin
			d.scan = ir_ctrl_pkg::SC_RUN;
		end

		// interrupt cycles only when enabled in interrupt mode
		if (!q.ctrl[`CTRL_IR_EN] || q.ctrl[`CTRL_IR_MODE]) begin
			d.ci = ir_ctrl_pkg::CI_CLOSED;
			d.per_cnt = 34'h000000000;
			d.samp_o_armed = 1'b0;
			d.samp_c_armed = 1'b0;
		end else if (us_tick) begin
			if (q.per_cnt >= 34'(q.tperiod) * 34'd1000 - 34'd1) begin
				d.per_cnt = 34'h000000000;
				d.ci = ir_ctrl_pkg::CI_OPEN;
				d.open_cnt = 20'h00000;
				d.samp_cnt = 20'h00000;
				d.samp_o_armed = 1'b1;
				d.samp_c_armed = 1'b0;
			end else begin
				d.per_cnt = q.per_cnt + 34'h000000001;
				d.samp_cnt = q.samp_cnt + 20'h00001;
				if (q.ci == ir_ctrl_pkg::CI_OPEN) begin
					d.open_cnt = q.open_cnt + 20'h00001;
					if (q.open_cnt >= q.topen - 20'h00001) begin
						d.ci = ir_ctrl_pkg::CI_CLOSED;
						d.samp_cnt = 20'h00000;
						d.samp_c_armed = 1'b1;
					end
				end
				if (q.samp_o_armed && q.ci == ir_ctrl_pkg::CI_OPEN && q.samp_cnt >= q.dly_open) begin
					d.samp_o = 1'b1;
					d.samp_o_armed = 1'b0;
				end
				if (q.samp_c_armed && q.ci == ir_ctrl_pkg::CI_CLOSED && q.samp_cnt >= q.dly_close) begin
					d.samp_c = 1'b1;
					d.samp_c_armed = 1'b0;
				end
			end
		end

		unique case (paddr)
			`OFS_CTRL: r = 32'(q.ctrl);
			`OFS_PFB: r = 32'(q.pfb);
			`OFS_TOPEN: r = 32'(q.topen);
			`OFS_TPERIOD: r = 32'(q.tperiod);
			`OFS_CORR: r = 32'(q.corr);
			`OFS_DLY_OPEN: r = 32'(q.dly_open);
			`OFS_DLY_CLOSE: r = 32'(q.dly_close);
			`OFS_TRIG: r = {31'h0, q.scan == ir_ctrl_pkg::SC_ARMED};
			`OFS_ROTATE: r = 32'(q.rotate);
			`OFS_NULL_E: r = 32'(q.null_e);
			`OFS_NULL_I: r = 32'(q.null_i);
			`OFS_STATUS: r = {26'h0, q.scan == ir_ctrl_pkg::SC_WAIT_LINE, q.br == ir_ctrl_pkg::BR_MEAS,
				q.ci == ir_ctrl_pkg::CI_OPEN, q.cmd_err, q.scan == ir_ctrl_pkg::SC_ARMED,
				q.scan == ir_ctrl_pkg::SC_RUN};
			default: r = 32'h00000000;
		endcase
		if (rd_acc) begin
			d.rdata = r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.topen <= 20'(`TOPEN_RST_US);
			q.tperiod <= 14'(`PERIOD_RST_MS);
			q.corr <= 8'(`CORR_RST);
			q.scan <= ir_ctrl_pkg::SC_IDLE;
			q.ci <= ir_ctrl_pkg::CI_CLOSED;
			q.br <= ir_ctrl_pkg::BR_OFF;
		end else begin
			q <= d;
		end
	end

	// zero wait state slave; read data registered in the setup cycle
	assign pready = 1'b1;
	assign prdata = q.rdata;
	assign pslverr = 1'b0;
	assign ir_comp_on = q.ctrl[`CTRL_IR_EN];
	assign pos_feedback_on = q.ctrl[`CTRL_IR_EN] && q.ctrl[`CTRL_IR_MODE];
	assign pfb_amount = q.pfb;
	assign ci_corr_pct = q.corr;
	assign cell_switch_open = q.ci == ir_ctrl_pkg::CI_OPEN;
	assign sample_open_pulse = q.samp_o;
	assign sample_close_pulse = q.samp_c;
	assign scan_start = q.start;
	assign scanning = q.scan == ir_ctrl_pkg::SC_RUN;
	assign rotator_mv = q.rotate;
	assign null_e_mv = q.null_e;
	assign null_i_milli = q.null_i;
	assign lpf_e_on = q.ctrl[`CTRL_LPF_E];
	assign lpf_i_on = q.ctrl[`CTRL_LPF_I];

endmodule

// [design/ir_ctrl_pkg.sv]
// types for the ir compensation and trigger control block
// assumes ir_ctrl_regs.svh for all numeric constants
package ir_ctrl_pkg;

	typedef enum logic [1:0] {
		SC_IDLE = 2'b00,
		SC_ARMED = 2'b01,
		SC_WAIT_LINE = 2'b10,
		SC_RUN = 2'b11
	} scan_e;

	typedef enum logic [1:0] {
		CI_CLOSED = 2'b00,
		CI_OPEN = 2'b01
	} ci_e;

	typedef enum logic [1:0] {
		BR_OFF = 2'b00,
		BR_MEAS = 2'b01,
		BR_HOLD = 2'b10
	} bias_e;

endpackage

// [design/ir_ctrl_regs.svh]
// register offsets, field positions, reset values and timing counts for the ir compensation block
// assumes a 32-bit apb slave at 125 mhz
`ifndef IR_CTRL_REGS_SVH
`define IR_CTRL_REGS_SVH

`define OFS_CTRL 12'h000
`define OFS_PFB 12'h004
`define OFS_TOPEN 12'h008
`define OFS_TPERIOD 12'h00C
`define OFS_CORR 12'h010
`define OFS_DLY_OPEN 12'h014
`define OFS_DLY_CLOSE 12'h018
`define OFS_TRIG 12'h01C
`define OFS_ROTATE 12'h020
`define OFS_NULL_E 12'h024
`define OFS_NULL_I 12'h028
`define OFS_STATUS 12'h02C

`define CTRL_IR_EN 0
`define CTRL_IR_MODE 1
`define CTRL_BOOST 2
`define CTRL_LINE_SYNC 3
`define CTRL_BIAS_EN 4
`define CTRL_LPF_E 5
`define CTRL_LPF_I 6

`define TRIG_ARM 0
`define TRIG_SW 1
`define TRIG_STOP 2

`define ST_SCANNING 0
`define ST_ARMED 1
`define ST_CMD_ERR 2
`define ST_SWITCH_OPEN 3
`define ST_MEAS_BUSY 4
`define ST_WAIT_LINE 5

`define TOPEN_STEP_US 32'd100
`define TOPEN_MAX_US 32'd1000000
`define TOPEN_BOOST_MIN_US 32'd10000
`define TOPEN_RST_US 32'd1000
`define PERIOD_MIN_MS 32'd1
`define PERIOD_MAX_MS 32'd10000
`define PERIOD_BOOST_MIN_MS 32'd200
`define PERIOD_RST_MS 32'd100
`define PFB_MAX 32'h00000FFF
`define CORR_MAX 32'd200
`define CORR_RST 32'd100
`define DLY_MAX_US 32'd1000000
`define DLY_OPEN_BOOST_MIN_US 32'd10000
`define DLY_CLOSE_BOOST_MIN_US 32'd20000
`define ROTATE_MAX_MV 32'd10000
`define NULL_E_LIM_MV 32'd15000
`define NULL_I_LIM 32'd2000

`define CLK_MHZ 125
`define US_CYCLES (`CLK_MHZ)

`endif

// [tb/analog_side.sv]
// far-side stand-in: ends scans, makes line crossings, gives bias levels
// assumes one-cycle scan_start pulses from the block
`timescale 1ns/1ns
module analog_side (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic scan_start,
	input wire logic line_go,
	output logic line_zero,
	output logic scan_done,
	output logic signed [15:0] bias_meas_e,
	output logic signed [15:0] bias_meas_i
);
	logic [5:0] lc_q;
	logic [5:0] dc_q;
	assign bias_meas_e = 16'sh03E6;
	assign bias_meas_i = 16'sh0366;
	// crossings only while the bench lets the mains run
	assign line_zero = line_go && lc_q == 6'h00;
	assign scan_done = dc_q == 6'h01;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lc_q <= 6'h01;
			dc_q <= 6'h00;
		end else begin
			lc_q <= lc_q + 6'h01;
			dc_q <= scan_start ? 6'h28 : (dc_q == 6'h00 ? 6'h00 : dc_q - 6'h01);
		end
	end
endmodule

// [tb/ir_chk_sva.sv]
// port checker for the ir compensation block
// assumes one clock pclk and asynchronous active-low presetn
`timescale 1ns/1ns
`include "ir_ctrl_regs.svh"
module ir_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic ir_comp_on,
	input wire logic pos_feedback_on,
	input wire logic [11:0] pfb_amount,
	input wire logic [7:0] ci_corr_pct,
	input wire logic [13:0] rotator_mv,
	input wire logic cell_switch_open,
	input wire logic scan_start,
	input wire logic scan_done,
	input wire logic scanning
);
	logic wr;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	assign wr = psel && penable && pwrite;
	a_no_wait: assert property (psel && penable |-> pready && !pslverr)
		else $error("apb access waited or failed");
	a_ir_enable: assert property (wr && paddr == `OFS_CTRL && pstrb[0] |=>
		ir_comp_on == $past(pwdata[0])) else $error("enable not applied");
	a_fb_mode: assert property (wr && paddr == `OFS_CTRL && pstrb[0] |=>
		pos_feedback_on == ($past(pwdata[0]) && $past(pwdata[1]))) else $error("mode not applied");
	a_pfb_clamp: assert property (wr && paddr == `OFS_PFB |=>
		pfb_amount == ($past(pwdata) > `PFB_MAX ? 12'hFFF : $past(pwdata[11:0]))) else $error("pfb wrong");
	a_corr_clamp: assert property (wr && paddr == `OFS_CORR |=>
		ci_corr_pct == ($past(pwdata) > `CORR_MAX ? 8'hC8 : $past(pwdata[7:0]))) else $error("corr wrong");
	a_rot_clamp: assert property (wr && paddr == `OFS_ROTATE |=>
		rotator_mv == ($past(pwdata) > `ROTATE_MAX_MV ? 14'h2710 : $past(pwdata[13:0]))) else $error("rotator wrong");
	a_start_run: assert property (scan_start |=> scanning)
		else $error("scan did not run");
	a_done_stop: assert property (scanning && scan_done && !scan_start |=> !scanning)
		else $error("scan did not stop");
	a_switch_mode: assert property (cell_switch_open |-> $past(ir_comp_on && !pos_feedback_on))
		else $error("switch open outside interrupt mode");
endmodule
bind ir_comp_trigger_control ir_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
	.pready, .pslverr, .ir_comp_on, .pos_feedback_on, .pfb_amount, .ci_corr_pct, .rotator_mv,
	.cell_switch_open, .scan_start, .scan_done, .scanning);

// [tb/testbench.sv]
// self-checking bench for the ir compensation block over apb
// assumes analog_side as far side; read data stands at the access edge
`timescale 1ns/1ns
`include "ir_ctrl_regs.svh"
module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hF;
	logic ext_trig = 1'b0;
	logic front_trig = 1'b0;
	logic line_go = 1'b0;
	logic [31:0] prdata, v;
	logic pready, pslverr, line_zero, scan_done, ir_comp_on, pos_feedback_on, cell_switch_open;
	logic sample_open_pulse, sample_close_pulse, scan_start, scanning, lpf_e_on, lpf_i_on;
	logic [11:0] pfb_amount;
	logic [7:0] ci_corr_pct;
	logic [13:0] rotator_mv;
	logic signed [15:0] bias_meas_e, bias_meas_i, null_e_mv, null_i_milli;
	int failures = 0;
	int tests_run = 0;
	int n;
	int m;
	int so_n = 0;
	int sc_n = 0;
	always #4 pclk = ~pclk;
	always @(posedge pclk) begin
		if (sample_open_pulse === 1'b1) begin
			so_n <= so_n + 1;
		end
		if (sample_close_pulse === 1'b1) begin
			sc_n <= sc_n + 1;
		end
	end
	ir_comp_trigger_control #(.US_CYC(2), .MEAS_US(2)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .ext_trig, .front_trig, .line_zero, .scan_done,
		.bias_meas_e, .bias_meas_i, .ir_comp_on, .pos_feedback_on, .pfb_amount, .ci_corr_pct,
		.cell_switch_open, .sample_open_pulse, .sample_close_pulse, .scan_start, .scanning, .rotator_mv,
		.null_e_mv, .null_i_milli, .lpf_e_on, .lpf_i_on);
	analog_side far (.pclk, .presetn, .scan_start, .line_go, .line_zero, .scan_done, .bias_meas_e, .bias_meas_i);
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rdat);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdat = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] u;
		xfer(1'b1, a, d, u);
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge pclk);
		#1;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		xfer(1'b0, a, 32'h0, d);
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %0h seen %0h", s, e, g);
		end
	endtask
	task automatic wrd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
		wr(a, d);
		rd(a, v);
		chk($sformatf("reg %0h", a), e, v);
	endtask
	task automatic span(input logic l, output int k);
		k = 0;
		while (cell_switch_open === l && k < 3000) begin
			cyc(1);
			k++;
		end
	endtask
	task automatic results;
		$display("tests %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge pclk);
		failures++;
		results;
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd(`OFS_CTRL, v);
		chk("ctrl reset", 32'h0, v);
		// open time kept below the period
		wr(`OFS_TOPEN, 32'h64);
		wr(`OFS_TPERIOD, 32'h1);
		wr(`OFS_CTRL, 32'h1);
		cyc(1);
		chk("comp on", 32'h1, {30'h0, pos_feedback_on, ir_comp_on});
		span(1'b0, n);
		span(1'b1, n);
		span(1'b0, m);
		chk("samp open", 32'h1, 32'(so_n));
		chk("samp close", 32'h1, 32'(sc_n));
		chk("open len", 32'(200), 32'(n));
		chk("period", 32'(2000), 32'(n + m));
		wr(`OFS_CTRL, 32'h63);
		cyc(1);
		chk("ctrl out", 32'hF, {28'h0, lpf_i_on, lpf_e_on, pos_feedback_on, ir_comp_on});
		wrd(`OFS_CTRL, 32'h0, 32'h0);
		chk("comp off", 32'h0, {31'h0, ir_comp_on});
		wrd(`OFS_PFB, 32'h1234, 32'hFFF);
		wrd(`OFS_TOPEN, 32'hFA, 32'hC8);
		wrd(`OFS_TOPEN, 32'h1E8480, 32'hF4240);
		wrd(`OFS_TPERIOD, 32'h4E20, 32'h2710);
		wrd(`OFS_CORR, 32'hC9, 32'hC8);
		wrd(`OFS_DLY_OPEN, 32'h7, 32'h7);
		wrd(`OFS_DLY_CLOSE, 32'hF4241, 32'hF4240);
		wrd(`OFS_ROTATE, 32'h2EE0, 32'h2710);
		wrd(12'h0F0, 32'h5, 32'h0);
		wr(`OFS_CTRL, 32'h4);
		wrd(`OFS_TOPEN, 32'h1F4, 32'h2710);
		wrd(`OFS_TPERIOD, 32'h32, 32'hC8);
		wrd(`OFS_DLY_OPEN, 32'h5, 32'h2710);
		wrd(`OFS_DLY_CLOSE, 32'h5, 32'h4E20);
		wr(`OFS_NULL_E, 32'h5);
		rd(`OFS_STATUS, v);
		chk("cmd err", 32'h4, v & 32'h4);
		chk("null refused", 32'h0, {16'h0, null_e_mv});
		wr(`OFS_CTRL, 32'h10);
		cyc(20);
		chk("null e auto", 32'hFC1A, {16'h0, null_e_mv});
		chk("null i auto", 32'hFC9A, {16'h0, null_i_milli});
		wr(`OFS_NULL_E, 32'hFFFFB1E0);
		wr(`OFS_NULL_I, 32'hBB8);
		cyc(1);
		chk("null e", 32'hC568, {16'h0, null_e_mv});
		chk("null i", 32'h07D0, {16'h0, null_i_milli});
		rd(`OFS_NULL_E, v);
		chk("null e read", 32'hFFFFC568, v);
		wr(`OFS_CTRL, 32'h0);
		wr(`OFS_TRIG, 32'h2);
		cyc(3);
		chk("sw scan", 32'h1, {31'h0, scanning});
		cyc(50);
		chk("scan end", 32'h0, {31'h0, scanning});
		wr(`OFS_CTRL, 32'h8);
		wr(`OFS_TRIG, 32'h2);
		cyc(10);
		chk("line wait", 32'h0, {31'h0, scanning});
		@(posedge pclk);
		line_go <= 1'b1;
		n = 0;
		while (scanning !== 1'b1 && n < 80) begin
			cyc(1);
			n++;
		end
		chk("line scan", 32'h1, {31'h0, scanning});
		@(posedge pclk);
		line_go <= 1'b0;
		cyc(50);
		@(posedge pclk);
		front_trig <= 1'b1;
		@(posedge pclk);
		front_trig <= 1'b0;
		cyc(3);
		chk("front scan", 32'h1, {31'h0, scanning});
		cyc(50);
		wr(`OFS_CTRL, 32'h0);
		wrd(`OFS_TRIG, 32'h1, 32'h1);
		cyc(10);
		chk("armed idle", 32'h0, {31'h0, scanning});
		@(posedge pclk);
		ext_trig <= 1'b1;
		cyc(4);
		chk("ext scan", 32'h1, {31'h0, scanning});
		@(posedge pclk);
		ext_trig <= 1'b0;
		cyc(50);
		wrd(`OFS_TRIG, 32'h4, 32'h0);
		results;
	end
endmodule
